// ==== fstmc_pkg.sv ====
// Constants, register map and types for the fan spin-up and tach mode control
package fstmc_pkg;

  // Register offsets
  localparam logic [7:0] FSTMC_REG_STATUS = 8'h02;
  localparam logic [7:0] FSTMC_REG_MASK = 8'h03;
  localparam logic [7:0] FSTMC_REG_TACH_LSB = 8'h46;
  localparam logic [7:0] FSTMC_REG_TACH_MSB = 8'h47;
  localparam logic [7:0] FSTMC_REG_LIMIT_LSB = 8'h48;
  localparam logic [7:0] FSTMC_REG_LIMIT_MSB = 8'h49;
  localparam logic [7:0] FSTMC_REG_PWM_TACH_CFG = 8'h4a;
  localparam logic [7:0] FSTMC_REG_SPIN_CFG = 8'h4b;
  localparam logic [7:0] FSTMC_REG_PWM_VALUE = 8'h4c;
  localparam logic [7:0] FSTMC_REG_PWM_FREQ = 8'h4d;

  // Field positions
  localparam int FSTMC_CFG_PROG_BIT = 5;
  localparam int FSTMC_CFG_POL_BIT = 4;
  localparam int FSTMC_CFG_CLKSEL_BIT = 3;
  localparam int FSTMC_SPIN_FAST_BIT = 5;
  localparam int FSTMC_ST_TACH_BIT = 0;
  localparam int FSTMC_ST_SPIN_BIT = 1;

  // Reset values
  localparam logic [7:0] FSTMC_CFG_RST = 8'h20;
  localparam logic [7:0] FSTMC_SPIN_RST = 8'h3f;
  localparam logic [4:0] FSTMC_FREQ_RST = 5'h17;
  localparam logic [15:0] FSTMC_LIMIT_RST = 16'hffff;

  // Tach mode codes
  localparam logic [1:0] FSTMC_TACH_PLAIN = 2'h0;
  localparam logic [1:0] FSTMC_TACH_FLAG = 2'h1;
  localparam logic [1:0] FSTMC_TACH_ACCURATE = 2'h2;
  localparam logic [1:0] FSTMC_TACH_GENTLE = 2'h3;

  // Duty in 1/64 steps; 64 is full on
  localparam logic [6:0] FSTMC_DUTY_FULL = 7'h40;
  localparam logic [6:0] FSTMC_DUTY_HALF = 7'h20;
  localparam logic [6:0] FSTMC_DUTY_HIGH = 7'h32;
  localparam logic [6:0] FSTMC_DUTY_MEAS_MIN = 7'h10;
  localparam logic [15:0] FSTMC_TACH_SAT = 16'hffff;

  // Timing
  localparam longint FSTMC_CORE_HZ = 200_000_000;
  localparam longint FSTMC_MCLK_FAST_HZ = 360_000;
  localparam longint FSTMC_MCLK_SLOW_HZ = 1_400;
  localparam longint FSTMC_TACH_TICK_HZ = 90_000;
  localparam longint FSTMC_SPIN_BASE_MS = 50;
  localparam int FSTMC_FAST_DIV = int'(FSTMC_CORE_HZ / FSTMC_MCLK_FAST_HZ);
  localparam int FSTMC_SLOW_DIV = int'(FSTMC_CORE_HZ / FSTMC_MCLK_SLOW_HZ);
  localparam int FSTMC_TACH_DIV = int'(FSTMC_CORE_HZ / FSTMC_TACH_TICK_HZ);
  localparam int FSTMC_SPIN_BASE_CYC = int'(FSTMC_CORE_HZ * FSTMC_SPIN_BASE_MS / 1000);

  typedef struct packed {
    logic progEn;
    logic polarity;
    logic clkSel;
    logic [1:0] tachMode;
  } fstmc_fan_cfg_t;

  typedef struct packed {
    logic fast;
    logic [1:0] duty;
    logic [2:0] spinTime;
  } fstmc_spin_cfg_t;

  typedef struct packed {
    logic spinDone;
    logic tachAlarm;
  } fstmc_events_t;

endpackage : fstmc_pkg

// ==== fstmc_fan_ctrl.sv ====
// Fan PWM start-up sequencer with tach measurement modes and register slave
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// RL1 - Bit 3 selects 360 kHz or 1.4 kHz
// RL2 - Software writes zero to reserved bit 2
// RL3 - Mode 00: plain tach, wrapping readings
// RL4 - Mode 01: all ones below minimum, duty untouched
// RL5 - Mode 01: limit below ones may alarm
// RL6 - Mode 10: duty raised, extended sensitivity
// RL7 - Mode 11: least disturbance, furthest sensitivity
// RL8 - Fast master clock forces mode 00
// RL9 - Spin config bits 7:6 read zero
// RL10 - Fast spin-up: full duty until time/RPM
// RL11 - Normal spin-up uses duty and time fields
// RL12 - Time code 000 skips spin-up
// RL13 - Duty codes: skip, 50%, ~78%, 100%
// RL14 - Time codes 0.05 s doubling to 3.2 s
// RL15 - PWM value reads zero during spin-up
// RL16 - PWM rate is master over 2n
// RL17 - Zero-to-nonzero duty starts spin-up
module fstmc_fan_ctrl
  import fstmc_pkg::*;
#(
  parameter int SLOW_DIV = FSTMC_SLOW_DIV,
  parameter int SPIN_BASE_CYC = FSTMC_SPIN_BASE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Fan pins
  input wire logic tachIn,
  output logic pwmPinOut,
  output logic pwmPinOe,
  // Interrupt
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  fstmc_fan_cfg_t fanCfg_ff;
  fstmc_spin_cfg_t spinCfg_ff;
  logic [5:0] pwmValue_ff;
  logic [4:0] freqN_ff;
  logic [15:0] tachLimit_ff;
  logic [15:0] tachCount_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic spinActive_ff;

  wire wrCfg = regWr && (regAddr == FSTMC_REG_PWM_TACH_CFG);
  wire wrSpin = regWr && (regAddr == FSTMC_REG_SPIN_CFG);
  wire wrPwm = regWr && (regAddr == FSTMC_REG_PWM_VALUE);
  wire wrFreq = regWr && (regAddr == FSTMC_REG_PWM_FREQ);
  wire wrLimLo = regWr && (regAddr == FSTMC_REG_LIMIT_LSB);
  wire wrLimHi = regWr && (regAddr == FSTMC_REG_LIMIT_MSB);
  wire wrStatus = regWr && (regAddr == FSTMC_REG_STATUS);
  wire wrMask = regWr && (regAddr == FSTMC_REG_MASK);

  // Bit 2 is never stored; software keeps it zero on write
  wire [7:0] cfgRead = {2'h0, fanCfg_ff.progEn, fanCfg_ff.polarity, fanCfg_ff.clkSel,
                        1'b0, fanCfg_ff.tachMode}; // RL2

  logic [7:0] nxt_rdata;
  always_comb begin
    if (regAddr == FSTMC_REG_PWM_TACH_CFG) begin
      nxt_rdata = cfgRead;
    end else if (regAddr == FSTMC_REG_SPIN_CFG) begin
      nxt_rdata = {2'h0, spinCfg_ff}; // RL9
    end else if (regAddr == FSTMC_REG_PWM_VALUE) begin
      nxt_rdata = spinActive_ff ? 8'h00 : {2'h0, pwmValue_ff}; // RL15
    end else if (regAddr == FSTMC_REG_PWM_FREQ) begin
      nxt_rdata = {3'h0, freqN_ff};
    end else if (regAddr == FSTMC_REG_TACH_LSB) begin
      nxt_rdata = tachCount_ff[7:0];
    end else if (regAddr == FSTMC_REG_TACH_MSB) begin
      nxt_rdata = tachCount_ff[15:8];
    end else if (regAddr == FSTMC_REG_LIMIT_LSB) begin
      nxt_rdata = tachLimit_ff[7:0];
    end else if (regAddr == FSTMC_REG_LIMIT_MSB) begin
      nxt_rdata = tachLimit_ff[15:8];
    end else if (regAddr == FSTMC_REG_STATUS) begin
      nxt_rdata = {6'h00, status_ff};
    end else if (regAddr == FSTMC_REG_MASK) begin
      nxt_rdata = {6'h00, mask_ff};
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= regRd ? nxt_rdata : 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fanCfg_ff <= fstmc_fan_cfg_t'({FSTMC_CFG_RST[5:3], FSTMC_CFG_RST[1:0]});
      spinCfg_ff <= fstmc_spin_cfg_t'(FSTMC_SPIN_RST[5:0]);
      pwmValue_ff <= 6'h00;
      freqN_ff <= FSTMC_FREQ_RST;
      tachLimit_ff <= FSTMC_LIMIT_RST;
      mask_ff <= 2'h0;
    end else begin
      if (wrCfg) fanCfg_ff <= fstmc_fan_cfg_t'({regWdata[5:3], regWdata[1:0]});
      if (wrSpin) spinCfg_ff <= fstmc_spin_cfg_t'(regWdata[5:0]);
      if (wrPwm && fanCfg_ff.progEn) pwmValue_ff <= regWdata[5:0];
      if (wrFreq) freqN_ff <= regWdata[4:0];
      if (wrLimLo) tachLimit_ff[7:0] <= regWdata;
      if (wrLimHi) tachLimit_ff[15:8] <= regWdata;
      if (wrMask) mask_ff <= regWdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master PWM clock and PWM period

  // Fast clock ignores the mode field
  wire [1:0] effMode = fanCfg_ff.clkSel ? fanCfg_ff.tachMode : FSTMC_TACH_PLAIN; // RL8
  wire [31:0] divEnd = fanCfg_ff.clkSel ? 32'(SLOW_DIV - 1) : 32'(FSTMC_FAST_DIV - 1); // RL1

  logic [31:0] divCnt_ff;
  logic mclkTick_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      divCnt_ff <= 32'h0;
      mclkTick_ff <= 1'b0;
    end else begin
      mclkTick_ff <= (divCnt_ff >= divEnd);
      divCnt_ff <= (divCnt_ff >= divEnd) ? 32'h0 : divCnt_ff + 32'h1; // RL1
    end
  end

  wire [4:0] effN = (freqN_ff == 5'h00) ? 5'h01 : freqN_ff; // RL16
  wire [5:0] periodTicks = {effN, 1'b0}; // RL16

  logic [5:0] phase_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_ff <= 6'h00;
    end else if (mclkTick_ff) begin
      phase_ff <= (phase_ff >= periodTicks - 6'h1) ? 6'h00 : phase_ff + 6'h1; // RL16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tach input and measurement

  logic [2:0] tachSync_ff;
  logic tachLvl_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // Idle line is pulled high; a low reset value would fake a rise
      tachSync_ff <= 3'h7;
      tachLvl_ff <= 1'b1;
    end else begin
      tachSync_ff <= {tachSync_ff[1:0], tachIn};
      if (tachSync_ff[1] == tachSync_ff[2]) tachLvl_ff <= tachSync_ff[2];
    end
  end
  wire tachRise = !tachLvl_ff && tachSync_ff[1] && tachSync_ff[2];

  // Mode 11 counts at half rate so the saturation point lies at a lower RPM
  logic [15:0] tickDiv_ff;
  logic tickHalf_ff;
  logic tachTick_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tickDiv_ff <= 16'h0;
      tickHalf_ff <= 1'b0;
      tachTick_ff <= 1'b0;
    end else begin
      tachTick_ff <= 1'b0;
      if (tickDiv_ff == 16'(FSTMC_TACH_DIV - 1)) begin
        tickDiv_ff <= 16'h0;
        tickHalf_ff <= !tickHalf_ff;
        tachTick_ff <= (effMode != FSTMC_TACH_GENTLE) || tickHalf_ff; // RL7
      end else begin
        tickDiv_ff <= tickDiv_ff + 16'h1;
      end
    end
  end

  logic [15:0] perCnt_ff;
  logic sampleNew_ff;
  wire perSat = (perCnt_ff == FSTMC_TACH_SAT);
  wire satFlag = perSat && tachTick_ff && (effMode != FSTMC_TACH_PLAIN);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      perCnt_ff <= 16'h0;
      tachCount_ff <= FSTMC_TACH_SAT;
      sampleNew_ff <= 1'b0;
    end else begin
      sampleNew_ff <= tachRise || satFlag;
      if (tachRise) begin
        tachCount_ff <= perCnt_ff;
        perCnt_ff <= 16'h0;
      end else if (satFlag) begin
        tachCount_ff <= FSTMC_TACH_SAT; // RL4 RL6 RL7
        perCnt_ff <= 16'h0;
      end else if (tachTick_ff) begin
        perCnt_ff <= perCnt_ff + 16'h1; // RL3
      end
    end
  end

  // All-ones readings trip a limit below all ones
  wire tachAlarm = sampleNew_ff && (tachCount_ff > tachLimit_ff); // RL5
  wire rpmReached = sampleNew_ff && (tachCount_ff <= tachLimit_ff);

  //////////////////////////////////////////////////////////////////////////////
  // Spin-up sequencer

  function automatic logic [31:0] spinCycles(input logic [2:0] code);
    spinCycles = 32'(SPIN_BASE_CYC) << (code - 3'h1); // RL14
  endfunction : spinCycles

  logic [6:0] spinDuty;
  always_comb begin
    case (spinCfg_ff.duty)
      2'h1: spinDuty = FSTMC_DUTY_HALF;
      2'h2: spinDuty = FSTMC_DUTY_HIGH;
      default: spinDuty = FSTMC_DUTY_FULL;
    endcase
    if (spinCfg_ff.fast) spinDuty = FSTMC_DUTY_FULL; // RL10 RL13
  end

  logic [5:0] prevPwm_ff;
  logic [31:0] spinCnt_ff;
  wire spinAllowed = (spinCfg_ff.spinTime != 3'h0) &&
                     (spinCfg_ff.fast || spinCfg_ff.duty != 2'h0); // RL12 RL13
  wire spinStart = (prevPwm_ff == 6'h00) && (pwmValue_ff != 6'h00) && spinAllowed; // RL17
  wire spinTimeUp = (spinCnt_ff >= spinCycles(spinCfg_ff.spinTime) - 32'h1); // RL11
  wire spinEnd = spinActive_ff && (spinTimeUp || (spinCfg_ff.fast && rpmReached)); // RL10

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prevPwm_ff <= 6'h00;
      spinActive_ff <= 1'b0;
      spinCnt_ff <= 32'h0;
    end else begin
      prevPwm_ff <= pwmValue_ff;
      if (spinStart && !spinActive_ff) begin
        spinActive_ff <= 1'b1; // RL17
        spinCnt_ff <= 32'h0;
      end else if (spinEnd) begin
        spinActive_ff <= 1'b0;
      end else if (spinActive_ff) begin
        spinCnt_ff <= spinCnt_ff + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Duty selection and pin drive

  wire [6:0] cmdDuty = {1'b0, pwmValue_ff};
  wire measBoost = (effMode == FSTMC_TACH_ACCURATE) && (cmdDuty != 7'h00) &&
                   (cmdDuty < FSTMC_DUTY_MEAS_MIN);
  wire [6:0] runDuty = measBoost ? FSTMC_DUTY_MEAS_MIN : cmdDuty; // RL4 RL6
  wire [6:0] liveDuty = spinActive_ff ? spinDuty : runDuty; // RL11 RL17
  wire [12:0] onLimit = 13'(liveDuty) * 13'(periodTicks);
  wire fanOn = ({1'b0, phase_ff, 6'h00} < onLimit);

  // Open-drain: pull low while off, release while on
  logic pwmOe_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwmOe_ff <= 1'b1;
    end else begin
      pwmOe_ff <= !fanOn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt

  fstmc_events_t evt;
  assign evt = '{spinDone: spinEnd, tachAlarm: tachAlarm};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      // A new event beats a same-cycle clear
      status_ff <= (status_ff & ~(wrStatus ? regWdata[1:0] : 2'h0)) | evt;
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign regRdata = rdata_ff;
  assign pwmPinOut = 1'b0;
  assign pwmPinOe = pwmOe_ff;
  assign irq = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  spinRsvd_a: assert property (@(posedge core_clk) disable iff (srst) // RL9
    regRd && regAddr == FSTMC_REG_SPIN_CFG |=> regRdata[7:6] == 2'h0)
    else $error("spin config upper bits not zero");

  fastMode_a: assert property (@(posedge core_clk) disable iff (srst) // RL8
    !fanCfg_ff.clkSel |-> effMode == FSTMC_TACH_PLAIN)
    else $error("fast clock not forcing plain tach mode");

  pwmReadZero_a: assert property (@(posedge core_clk) disable iff (srst) // RL15
    regRd && regAddr == FSTMC_REG_PWM_VALUE && spinActive_ff |=> regRdata == 8'h00)
    else $error("pwm value readable during spin-up");

  skipSpin_a: assert property (@(posedge core_clk) disable iff (srst) // RL12
    $rose(spinActive_ff) |-> $past(spinCfg_ff.spinTime) != 3'h0)
    else $error("spin-up ran with zero time code");

  fastDuty_a: assert property (@(posedge core_clk) disable iff (srst) // RL10
    spinActive_ff && spinCfg_ff.fast |-> liveDuty == 7'h40)
    else $error("fast spin-up not at full duty");

  halfDuty_a: assert property (@(posedge core_clk) disable iff (srst) // RL13
    spinActive_ff && !spinCfg_ff.fast && spinCfg_ff.duty == 2'h1 |-> liveDuty == 7'h20)
    else $error("spin-up duty code 01 not half");

  satRead_a: assert property (@(posedge core_clk) disable iff (srst) // RL4
    satFlag && !tachRise |=> tachCount_ff == FSTMC_TACH_SAT && sampleNew_ff)
    else $error("saturated tach not all ones");

  freqZero_a: assert property (@(posedge core_clk) disable iff (srst) // RL16
    freqN_ff == 5'h00 |-> periodTicks == 6'h02)
    else $error("zero frequency code not mapped to one");

  spinKick_a: assert property (@(posedge core_clk) disable iff (srst) // RL17
    spinStart && !spinActive_ff |=> spinActive_ff ##1 (spinActive_ff || spinEnd || $past(spinEnd)))
    else $error("spin-up did not start on duty rise");

  irqLevel_a: assert property (@(posedge core_clk) disable iff (srst)
    |(status_ff & mask_ff) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule : fstmc_fan_ctrl

`default_nettype wire

// ==== fstmc_fan_model.sv ====
// Behavioural four-pin fan: tach output with a fixed rotation period
`timescale 1ns/10ps
`default_nettype none
module fstmc_fan_model #(
  parameter int HALF_CYC = 4444
) (
  // Clock
  input wire logic core_clk,
  // Control from bench
  input wire logic run,
  // Tach pin
  output logic tachOut
);
  int cnt;
  // Open collector with pull-up: stopped fan leaves the line high
  always @(posedge core_clk) begin
    if (!run) begin
      tachOut <= 1'b1;
      cnt <= 0;
    end else if (cnt == HALF_CYC - 1) begin
      tachOut <= ~tachOut;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : fstmc_fan_model
`default_nettype wire

// ==== fstmc_fan_ctrl_test.sv ====
// Self-checking testbench for the fan spin-up and tach mode control
`timescale 1ns/10ps
`default_nettype none
module fstmc_fan_ctrl_test;
  import fstmc_pkg::*;
  logic core_clk, srst, regWr, regRd, tachIn, pwmPinOut, pwmPinOe, irq, run, rdPend;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [7:0] expQ[$];
  int tolQ[$];
  int mismatches, n_compared;
  logic [7:0] cfgTab [6] = '{8'h0b, 8'h13, 8'h1b, 8'h2b, 8'h38, 8'h07};
  int dtyTab [6] = '{32, 50, 64, 64, 0, 0};
  int modeOn [4] = '{80, 80, 320, 80};

  fstmc_fan_ctrl #(.SLOW_DIV(40), .SPIN_BASE_CYC(400)) fstmc_fan_ctrl_i (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tachIn(tachIn),
    .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe), .irq(irq));
  fstmc_fan_model fstmc_fan_model_i (.core_clk(core_clk), .run(run), .tachOut(tachIn));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic near(input int seen, input int exp, input int tol);
    if (seen >= exp - tol && seen <= exp + tol) check(exp, exp);
    else check(seen, exp);
  endtask : near

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Each access lowers the other strobe, so back-to-back calls never leave both strobes raised
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input int t);
    expQ.push_back(e);
    tolQ.push_back(t);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic waitc(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : waitc

  task automatic measure(input int w, output int on, output int edg);
    logic prev;
    waitc(1);
    on = 0;
    edg = 0;
    prev = pwmPinOe;
    repeat (w) begin
      @(posedge core_clk);
      if (pwmPinOe === 1'b0) on++;
      if (pwmPinOe !== prev) edg++;
      prev = pwmPinOe;
    end
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rdPend === 1'b1) begin
      logic [7:0] e;
      int t;
      e = expQ.pop_front();
      t = tolQ.pop_front();
      if (t != 0 && regRdata >= e - t && regRdata <= e + t) check(e, e);
      else check(regRdata, e);
    end
    rdPend <= regRd;
  end

  initial begin
    repeat (98000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    int on, edg, v, r;
    {srst, regWr, regRd, run} = 4'h8;
    regAddr = 8'h00;
    regWdata = 8'h00;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'h685136bc));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(FSTMC_REG_PWM_TACH_CFG, FSTMC_CFG_RST, 0);
    rd(FSTMC_REG_SPIN_CFG, FSTMC_SPIN_RST, 0);
    rd(FSTMC_REG_PWM_VALUE, 8'h00, 0);
    rd(8'h10, 8'h00, 0);
    rd(FSTMC_REG_TACH_LSB, 8'hff, 0);
    check(pwmPinOe, 1'b1);
    check(pwmPinOut, 1'b0);
    r = $urandom;
    wr(FSTMC_REG_SPIN_CFG, r[7:0]);
    rd(FSTMC_REG_SPIN_CFG, r[7:0] & 8'h3f, 0);
    // Slow master clock, mode 01; reserved bit kept zero
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h29);
    wr(FSTMC_REG_PWM_FREQ, 8'h10);
    for (int i = 0; i < 6; i++) begin
      v = $urandom_range(63, 1);
      wr(FSTMC_REG_PWM_VALUE, 8'h00);
      wr(FSTMC_REG_SPIN_CFG, cfgTab[i]);
      wr(FSTMC_REG_PWM_VALUE, v[7:0]);
      measure(1280, on, edg);
      near(on, ((dtyTab[i] ? dtyTab[i] : v) + 1) / 2 * 40, 8);
      rd(FSTMC_REG_PWM_VALUE, dtyTab[i] ? 8'h00 : v[7:0], 0);
      waitc(400);
      rd(FSTMC_REG_PWM_VALUE, v[7:0], 0);
    end
    // Measurement modes on a low nonzero duty
    for (int m = 0; m < 4; m++) begin
      wr(FSTMC_REG_PWM_TACH_CFG, 8'h28 | m[7:0]);
      wr(FSTMC_REG_PWM_VALUE, 8'h04);
      measure(1280, on, edg);
      near(on, modeOn[m], 8);
    end
    // Fast master clock, n of one and n of zero give the same rate
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h23);
    for (int n = 0; n < 2; n++) begin
      wr(FSTMC_REG_PWM_FREQ, n[7:0]);
      measure(2220, on, edg);
      near(edg, 4, 1);
    end
    // Spin-up done event, mask and write-one-to-clear
    rd(FSTMC_REG_STATUS, 8'h02, 0);
    waitc(2);
    check(irq, 1'b0);
    wr(FSTMC_REG_MASK, 8'h02);
    waitc(3);
    check(irq, 1'b1);
    wr(FSTMC_REG_STATUS, 8'h02);
    waitc(3);
    check(irq, 1'b0);
    rd(FSTMC_REG_STATUS, 8'h00, 0);
    // Tach readings from a running fan, period of four ticks
    run <= 1'b1;
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h29);
    waitc(18000);
    rd(FSTMC_REG_TACH_LSB, 8'h04, 1);
    rd(FSTMC_REG_TACH_MSB, 8'h00, 0);
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h2b);
    waitc(18000);
    rd(FSTMC_REG_TACH_LSB, 8'h02, 1);
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h23);
    waitc(18000);
    rd(FSTMC_REG_TACH_LSB, 8'h04, 1);
    // Limit of one, below the reading of four, raises the alarm on a healthy fan
    wr(FSTMC_REG_PWM_TACH_CFG, 8'h29);
    wr(FSTMC_REG_LIMIT_LSB, 8'h01);
    wr(FSTMC_REG_LIMIT_MSB, 8'h00);
    wr(FSTMC_REG_MASK, 8'h01);
    waitc(9000);
    rd(FSTMC_REG_STATUS, 8'h01, 0);
    waitc(2);
    check(irq, 1'b1);
    // Fast spin-up ends on the first reading within the limit
    wr(FSTMC_REG_LIMIT_LSB, 8'hff);
    wr(FSTMC_REG_LIMIT_MSB, 8'hff);
    wr(FSTMC_REG_PWM_VALUE, 8'h00);
    wr(FSTMC_REG_SPIN_CFG, 8'h27);
    wr(FSTMC_REG_PWM_VALUE, 8'h11);
    waitc(9000);
    rd(FSTMC_REG_PWM_VALUE, 8'h11, 0);
    waitc(3);
    stop_test();
  end
endmodule : fstmc_fan_ctrl_test
`default_nettype wire
